// file: common/ebc_pkg.sv
// Package of the external bus cycle controller: register map, field layout,
// reset values, phase state codes and clock divider defaults.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package ebc_pkg;

    // Register byte offsets.
    localparam logic [7:0] EBC_CTRL_OFS   = 8'h00;
    localparam logic [7:0] EBC_STATUS_OFS = 8'h04;
    localparam logic [7:0] EBC_TIMING_OFS = 8'h10;

    // Number of external regions, each with its own timing register.
    localparam int EBC_REGIONS = 4;

    // Timing register fields: bit position of each field.
    localparam int EBC_F_AB    = 0;  // 1 bit: 0 = one period, 1 = two periods.
    localparam int EBC_F_WIN   = 1;  // 2 bits: extra periods on window change.
    localparam int EBC_F_C     = 3;  // 2 bits: command delay 0..3.
    localparam int EBC_F_D     = 5;  // 1 bit: data setup / tristate 0..1.
    localparam int EBC_F_E     = 6;  // 5 bits: access length minus one.
    localparam int EBC_F_F     = 11; // 2 bits: hold phase 0..3.
    localparam int EBC_F_RDYEN = 13; // Ready handshake in use.
    localparam int EBC_F_ASYNC = 14; // Ready taken asynchronously.
    localparam int EBC_F_POL   = 15; // Ready active level.
    localparam int EBC_TIMING_W = 16;

    // Reset values.
    localparam logic [EBC_TIMING_W-1:0] EBC_TIMING_RST = 16'h07C1;
    localparam logic                    EBC_CTRL_RST   = 1'b0;

    // Clock periods of aclk per CPU clock period.
    localparam int EBC_CPU_DIV = 4;

    // AXI responses.
    localparam logic [1:0] EBC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] EBC_RESP_SLVERR = 2'h2;

    // Bus cycle and arbitration states, one-hot.
    typedef enum logic [9:0] {
        EBC_IDLE    = 10'h001,
        EBC_AB      = 10'h002,
        EBC_C       = 10'h004,
        EBC_D       = 10'h008,
        EBC_E       = 10'h010,
        EBC_RDY     = 10'h020,
        EBC_F       = 10'h040,
        EBC_RELEASE = 10'h080,
        EBC_HELD    = 10'h100,
        EBC_REGAIN  = 10'h200
    } ebc_state_t;

endpackage : ebc_pkg

// file: core/ebc_core.sv
// External bus cycle controller: runs each external access as programmable
// phases, stretches the access with a ready handshake and hands the bus to an
// external master on request.
// Assumes an AXI4-Lite master for configuration and a requester on aclk.
// How it works
// - Cycle runs address, command, data, access, hold phases.
// - Phase lengths come from per-region timing registers.
// - Address setup one/two periods, plus window extra.
// - Command delay 0..3, data setup 0..1 periods.
// - Hold phase lasts 0..3 periods.
// - Access 1..32 periods, optionally ready-stretched.
// - Ready active level is configurable.
// - Asynchronous ready adds a stage, one wait minimum.
// - Inactive ready waits again, active ready ends.
// - Read data captured on strobe-rise edge.
// - Hold grants only after current cycle ends.
// - Release drives controls inactive, then floats, latch low.
// - Regain starts only when hold goes high.
// - Regain drives controls inactive before next cycle.
`timescale 1ns/100ps
module ebc_core
    import ebc_pkg::*;
#(
    parameter int ADDR_W  = 24,
    parameter int DATA_W  = 16,
    parameter int CPU_DIV = EBC_CPU_DIV
)(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite register slave.
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Internal access requests.
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic              req_high_byte,
    input  wire logic [1:0]        req_region,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   done,
    output logic [DATA_W-1:0]      rdata,
    // External bus pins.
    output logic                   reference_clock_output,
    output logic [ADDR_W-1:0]      ext_addr,
    output logic                   ext_addr_latch,
    output logic                   high_byte_enable_n,
    output logic                   read_n,
    output logic                   write_n,
    output logic                   ctrl_oe_n,
    output logic [DATA_W-1:0]      ext_data_out,
    output logic                   ext_data_oe_n,
    input  wire logic [DATA_W-1:0] ext_data_in,
    input  wire logic              ext_ready,
    input  wire logic              hold_n,
    output logic                   hold_acknowledge_n,
    output logic                   bus_request_out_n
);

    // Two-flop synchronisers for every pin input; ready has a third stage read in async mode.
    logic              rdy_s1_reg, rdy_s2_reg, rdy_s3_reg, hold_s1_reg, hold_s2_reg;
    logic [DATA_W-1:0] din_s1_reg, din_s2_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdy_s1_reg  <= 1'b0;
            rdy_s2_reg  <= 1'b0;
            rdy_s3_reg  <= 1'b0;
            hold_s1_reg <= 1'b1;
            hold_s2_reg <= 1'b1;
            din_s1_reg  <= '0;
            din_s2_reg  <= '0;
        end
        else
        begin
            rdy_s1_reg  <= ext_ready;
            rdy_s2_reg  <= rdy_s1_reg;
            rdy_s3_reg  <= rdy_s2_reg; // Extra stage for asynchronous ready.
            hold_s1_reg <= hold_n;
            hold_s2_reg <= hold_s1_reg;
            din_s1_reg  <= ext_data_in;
            din_s2_reg  <= din_s1_reg;
        end
    end

    // CPU clock period divider: tick ends each period, reference clock follows.
    logic [7:0] div_reg, div_next;
    logic       tick;
    always_comb
    begin
        tick     = (div_reg == 8'(CPU_DIV - 1));
        div_next = tick ? 8'h00 : div_reg + 8'h01;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            div_reg <= 8'h00;
        else
            div_reg <= div_next;
    end
    assign reference_clock_output = (div_reg < 8'(CPU_DIV / 2));

    // Configuration registers.
    logic                    enable_reg, enable_next;
    logic [EBC_TIMING_W-1:0] timing_reg [EBC_REGIONS];
    logic [EBC_TIMING_W-1:0] timing_next [EBC_REGIONS];

    // Bus cycle state.
    ebc_state_t        state_reg, state_next;
    logic [5:0]        cnt_reg, cnt_next;
    logic              write_reg, write_next, hbe_reg, hbe_next, first_reg, first_next;
    logic [1:0]        region_reg, region_next, last_reg, last_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic              done_reg, done_next;
    logic [EBC_TIMING_W-1:0] cfg;
    logic              rdy_seen;

    // Length of a phase in CPU periods for the current region's timing.
    function automatic logic [5:0] phase_len(input ebc_state_t st, input logic [EBC_TIMING_W-1:0] t,
                                             input logic win_change);
        logic [5:0] len;
        len = 6'h00;
        unique case (st)
            EBC_AB:  len = 6'(t[EBC_F_AB]) + 6'h01 + (win_change ? 6'(t[EBC_F_WIN +: 2]) : 6'h00);
            EBC_C:   len = 6'(t[EBC_F_C +: 2]);
            EBC_D:   len = 6'(t[EBC_F_D]);
            EBC_E:   len = 6'(t[EBC_F_E +: 5]) + 6'h01;
            EBC_F:   len = 6'(t[EBC_F_F +: 2]);
            default: len = 6'h01;
        endcase
        return len;
    endfunction : phase_len

    // Next phase after a given one, skipping phases programmed to zero length.
    function automatic ebc_state_t after(input ebc_state_t st, input logic [EBC_TIMING_W-1:0] t);
        ebc_state_t nx;
        nx = EBC_IDLE;
        if (st == EBC_AB && t[EBC_F_C +: 2] != 2'h0)
            nx = EBC_C;
        else if ((st == EBC_AB || st == EBC_C) && t[EBC_F_D])
            nx = EBC_D;
        else if (st == EBC_AB || st == EBC_C || st == EBC_D)
            nx = EBC_E;
        else if (st == EBC_E && t[EBC_F_RDYEN])
            nx = EBC_RDY;
        else if ((st == EBC_E || st == EBC_RDY) && t[EBC_F_F +: 2] != 2'h0)
            nx = EBC_F;
        return nx;
    endfunction : after

    // Phase sequencing, ready evaluation and bus arbitration.
    always_comb
    begin
        cfg         = timing_reg[region_reg];
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        write_next  = write_reg;
        hbe_next    = hbe_reg;
        first_next  = first_reg;
        region_next = region_reg;
        last_next   = last_reg;
        addr_next   = addr_reg;
        wdata_next  = wdata_reg;
        rdata_next  = rdata_reg;
        done_next   = 1'b0;
        req_ready   = 1'b0;
        // Active level chosen by configuration; async mode reads the third stage.
        rdy_seen    = ((cfg[EBC_F_ASYNC] ? rdy_s3_reg : rdy_s2_reg) == cfg[EBC_F_POL]);
        unique case (state_reg)
            EBC_IDLE:
            begin
                if (tick && !hold_s2_reg)
                    state_next = EBC_RELEASE;
                else if (tick && enable_reg)
                begin
                    req_ready = 1'b1;
                    if (req_valid)
                    begin
                        write_next  = req_write;
                        hbe_next    = req_high_byte;
                        region_next = req_region;
                        addr_next   = req_addr;
                        wdata_next  = req_wdata;
                        last_next   = req_region;
                        cnt_next    = phase_len(EBC_AB, timing_reg[req_region], req_region != last_reg);
                        state_next  = EBC_AB;
                    end
                end
            end
            EBC_AB, EBC_C, EBC_D, EBC_E, EBC_RDY, EBC_F:
            begin
                // A ready wait ends on an active sample; async mode skips its first.
                if (tick && (state_reg == EBC_RDY ? rdy_seen && !(cfg[EBC_F_ASYNC] && first_reg) : cnt_reg <= 6'h01))
                begin
                    state_next = after(state_reg, cfg);
                    cnt_next   = phase_len(after(state_reg, cfg), cfg, 1'b0);
                    // Read data taken on the edge where the strobe rises.
                    if (!write_reg && (state_reg == EBC_RDY || (state_reg == EBC_E && !cfg[EBC_F_RDYEN])))
                        rdata_next = din_s2_reg;
                    if (after(state_reg, cfg) == EBC_IDLE)
                        done_next = 1'b1;
                end
                else if (tick)
                    cnt_next = cnt_reg - 6'h01;
                if (tick)
                    first_next = (state_reg != EBC_RDY);
            end
            EBC_RELEASE:
            begin
                if (tick)
                    state_next = EBC_HELD;
            end
            EBC_HELD:
            begin
                if (tick && hold_s2_reg)
                    state_next = EBC_REGAIN;
            end
            EBC_REGAIN:
            begin
                if (tick)
                    state_next = EBC_IDLE;
            end
            default:
                state_next = EBC_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg  <= EBC_IDLE;
            cnt_reg    <= 6'h00;
            write_reg  <= 1'b0;
            hbe_reg    <= 1'b0;
            first_reg  <= 1'b0;
            region_reg <= 2'h0;
            last_reg   <= 2'h0;
            addr_reg   <= '0;
            wdata_reg  <= '0;
            rdata_reg  <= '0;
            done_reg   <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            write_reg  <= write_next;
            hbe_reg    <= hbe_next;
            first_reg  <= first_next;
            region_reg <= region_next;
            last_reg   <= last_next;
            addr_reg   <= addr_next;
            wdata_reg  <= wdata_next;
            rdata_reg  <= rdata_next;
            done_reg   <= done_next;
        end
    end

    // Pin drive decoded from the phase; the address latch is never floated.
    logic in_cycle, strobe;
    always_comb
    begin
        in_cycle = (state_reg != EBC_IDLE) && (state_reg != EBC_RELEASE) && (state_reg != EBC_HELD)
                   && (state_reg != EBC_REGAIN);
        strobe   = (state_reg == EBC_E) || (state_reg == EBC_RDY);
    end
    assign ext_addr           = addr_reg;
    assign ext_addr_latch     = (state_reg == EBC_AB);
    assign high_byte_enable_n = !(in_cycle && hbe_reg);
    assign read_n             = !(strobe && !write_reg);
    assign write_n            = !(strobe && write_reg);
    assign ctrl_oe_n          = (state_reg == EBC_HELD);
    assign ext_data_out       = wdata_reg;
    assign ext_data_oe_n      = !(write_reg && (state_reg == EBC_D || strobe || state_reg == EBC_F));
    assign hold_acknowledge_n = !(state_reg == EBC_HELD);
    assign bus_request_out_n  = !(state_reg == EBC_HELD && req_valid);
    assign done               = done_reg;
    assign rdata              = rdata_reg;

    // AXI4-Lite slave: address and data latched in either order, then answered.
    logic        aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
    logic [7:0]  awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
    logic [1:0]  br_reg, br_next, rr_reg, rr_next, ws_reg, ws_next;
    always_comb
    begin
        aw_next     = aw_reg;
        w_next      = w_reg;
        bv_next     = bv_reg;
        rv_next     = rv_reg;
        awa_next    = awa_reg;
        wd_next     = wd_reg;
        rd_next     = rd_reg;
        br_next     = br_reg;
        rr_next     = rr_reg;
        ws_next     = ws_reg;
        enable_next = enable_reg;
        timing_next = timing_reg;
        if (s_axi_awvalid && !aw_reg)
        begin
            aw_next  = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_reg)
        begin
            w_next  = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb[1:0];
        end
        if (aw_reg && w_reg && !bv_reg)
        begin
            aw_next = 1'b0;
            w_next  = 1'b0;
            bv_next = 1'b1;
            br_next = EBC_RESP_OKAY;
            if (awa_reg[7:2] == EBC_CTRL_OFS[7:2])
            begin
                if (ws_reg[0])
                    enable_next = wd_reg[0];
            end
            else if (awa_reg[7:4] == EBC_TIMING_OFS[7:4])
            begin
                // Timing changes are seen at once, also by the remaining phases of a cycle in progress that uses the region.
                if (ws_reg[0])
                    timing_next[awa_reg[3:2]][7:0] = wd_reg[7:0];
                if (ws_reg[1])
                    timing_next[awa_reg[3:2]][15:8] = wd_reg[15:8];
            end
            else if (awa_reg[7:2] != EBC_STATUS_OFS[7:2])
                br_next = EBC_RESP_SLVERR;
        end
        if (bv_reg && s_axi_bready)
            bv_next = 1'b0;
        if (s_axi_arvalid && !rv_reg)
        begin
            rv_next = 1'b1;
            rr_next = EBC_RESP_OKAY;
            rd_next = 32'h0000_0000;
            if (s_axi_araddr[7:2] == EBC_CTRL_OFS[7:2])
                rd_next[0] = enable_reg;
            else if (s_axi_araddr[7:2] == EBC_STATUS_OFS[7:2])
                rd_next = {20'h00000, 2'(region_reg), state_reg};
            else if (s_axi_araddr[7:4] == EBC_TIMING_OFS[7:4])
                rd_next[15:0] = timing_reg[s_axi_araddr[3:2]];
            else
                rr_next = EBC_RESP_SLVERR;
        end
        else if (rv_reg && s_axi_rready)
            rv_next = 1'b0;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_reg     <= 1'b0;
            w_reg      <= 1'b0;
            bv_reg     <= 1'b0;
            rv_reg     <= 1'b0;
            awa_reg    <= 8'h00;
            wd_reg     <= 32'h0000_0000;
            rd_reg     <= 32'h0000_0000;
            br_reg     <= 2'h0;
            rr_reg     <= 2'h0;
            ws_reg     <= 2'h0;
            enable_reg <= EBC_CTRL_RST;
            for (int i = 0; i < EBC_REGIONS; i++)
                timing_reg[i] <= EBC_TIMING_RST;
        end
        else
        begin
            aw_reg     <= aw_next;
            w_reg      <= w_next;
            bv_reg     <= bv_next;
            rv_reg     <= rv_next;
            awa_reg    <= awa_next;
            wd_reg     <= wd_next;
            rd_reg     <= rd_next;
            br_reg     <= br_next;
            rr_reg     <= rr_next;
            ws_reg     <= ws_next;
            enable_reg <= enable_next;
            timing_reg <= timing_next;
        end
    end
    assign s_axi_awready = !aw_reg;
    assign s_axi_wready  = !w_reg;
    assign s_axi_bvalid  = bv_reg;
    assign s_axi_bresp   = br_reg;
    assign s_axi_arready = !rv_reg;
    assign s_axi_rvalid  = rv_reg;
    assign s_axi_rdata   = rd_reg;
    assign s_axi_rresp   = rr_reg;

endmodule : ebc_core

// file: dv/ebc_props.sv
// Checker of phase order, strobe and bus arbitration relations of ebc_core.
// Assumes it is bound to ebc_core and sees only that module's ports.
`timescale 1ns/100ps
module ebc_props
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req_ready,
    input wire logic done,
    input wire logic ext_addr_latch,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic ctrl_oe_n,
    input wire logic ext_data_oe_n,
    input wire logic hold_n,
    input wire logic hold_acknowledge_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Controls driven but inactive, the state around every bus hand-over.
    sequence s_off;
        !ctrl_oe_n && read_n && write_n && !ext_addr_latch;
    endsequence
    // Minimum phase lengths assume the bench runs two clocks per CPU period.
    property p_ab_len;
        $rose(ext_addr_latch) |-> (ext_addr_latch && read_n && write_n)[*2];
    endproperty
    property p_e_len;
        $fell(read_n) |-> (!read_n && !ext_addr_latch)[*2];
    endproperty
    property p_wr_oe;
        !write_n |-> !ext_data_oe_n;
    endproperty
    property p_no_ack;
        !(read_n && write_n) |-> hold_acknowledge_n;
    endproperty
    property p_held;
        !hold_acknowledge_n |-> ctrl_oe_n && !req_ready;
    endproperty
    property p_release;
        hold_acknowledge_n && (ctrl_oe_n || !read_n || !write_n || ext_addr_latch) |=> hold_acknowledge_n;
    endproperty
    property p_regain;
        $rose(hold_acknowledge_n) |-> s_off;
    endproperty
    property p_ack_drop;
        $rose(hold_n) |-> ##[1:16] hold_acknowledge_n;
    endproperty
    property p_hold_stay;
        !hold_acknowledge_n && !hold_n |=> !hold_acknowledge_n;
    endproperty
    property p_done;
        done |=> !done && read_n && write_n;
    endproperty
    a_ab_len: assert property (p_ab_len) else $error("address phase too short");
    a_e_len: assert property (p_e_len) else $error("access phase too short");
    a_wr_oe: assert property (p_wr_oe) else $error("write data not driven");
    a_no_ack: assert property (p_no_ack) else $error("bus granted mid cycle");
    a_held: assert property (p_held) else $error("controls driven while held");
    a_release: assert property (p_release) else $error("release not inactive");
    a_regain: assert property (p_regain) else $error("regain not inactive");
    a_ack_drop: assert property (p_ack_drop) else $error("acknowledge stuck");
    a_hold_stay: assert property (p_hold_stay) else $error("bus taken back early");
    a_done: assert property (p_done) else $error("done not a pulse");
endmodule : ebc_props
bind ebc_core ebc_props i_props (.*);

// file: dv/ebc_mem_model.sv
// Model of a memory with a ready handshake on the external bus.
// Assumes the reference clock output paces it and one bus master at a time.
`timescale 1ns/100ps
module ebc_mem_model
(
    input  wire logic        refclk,
    input  wire logic [23:0] addr,
    input  wire logic        read_n,
    input  wire logic        write_n,
    input  wire logic [15:0] wdata,
    input  wire logic        rdy_pol,
    input  wire integer      rdy_wait,
    output logic [15:0]      rdata,
    output logic             ready
);
    logic [15:0] mem [4];
    logic [15:0] junk = 16'h5AA5;
    int          cnt  = 0;
    initial for (int i = 0; i < 4; i++) mem[i] = 16'h0123 + 16'(i) * 16'h1111;
    // Count periods on the falling edge, clear of strobe changes; junk defeats stale data.
    always @(negedge refclk)
    begin
        junk <= ~junk;
        cnt  <= (read_n && write_n) ? 0 : cnt + 1;
    end
    // Ready follows the reference clock and goes inactive as soon as the strobe rises.
    assign ready = (!(read_n && write_n) && cnt >= rdy_wait) ? rdy_pol : !rdy_pol;
    // Data are released once the read strobe rises.
    assign rdata = !read_n ? mem[addr[1:0]] : junk;
    always @(posedge write_n) if (!$isunknown(addr)) mem[addr[1:0]] <= wdata;
endmodule : ebc_mem_model

// file: dv/ebc_tb.sv
// Self-checking bench of ebc_core: registers, phase lengths, ready and hold.
// Assumes ebc_pkg, the memory model and the checker are compiled first.
`timescale 1ns/100ps
module testbench;
    import ebc_pkg::*;
    localparam int DIV = 2;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, req_valid = 0, req_write = 0, req_high_byte = 0;
    logic        hold_n = 1, rdy_pol = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, req_ready, done, reference_clock_output, ext_addr_latch, high_byte_enable_n;
    logic        read_n, write_n, ctrl_oe_n, ext_data_oe_n, ext_ready, hold_acknowledge_n, bus_request_out_n;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, req_region = 2'h0;
    logic [23:0] req_addr = 24'h0, ext_addr;
    logic [15:0] req_wdata = 16'h0, rdata, ext_data_out, ext_data_in, q;
    int          errors = 0, checked = 0, rdy_wait = 0, c, n, lat [2][2][2];
    ebc_core #(.CPU_DIV(DIV)) i_dut (.*);
    ebc_mem_model i_mem (.refclk(reference_clock_output), .addr(ext_addr), .read_n, .write_n,
        .wdata(ext_data_out), .rdy_pol, .rdy_wait, .rdata(ext_data_in), .ready(ext_ready));
    // Free-running system clock.
    always #5 aclk = ~aclk;
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Every polling wait passes through here, so a hang ends in the closing report.
    task automatic step(inout int k);
        @(posedge aclk);
        if (++k > 3000)
        begin
            errors++;
            $display("[ERR] wait expected progress seen none");
            test_done();
        end
    endtask : step
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            step(k);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            step(k);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
    endtask : axi_rd
    // One bus cycle: c counts clocks from the take to the done pulse.
    task automatic acc(input logic w, input logic [1:0] rg, input logic [23:0] a, input logic [15:0] d);
        int k;
        k = 0;
        @(posedge aclk);
        {req_valid, req_write, req_high_byte, req_region, req_addr, req_wdata} <= {1'b1, w, w, rg, a, d};
        do step(k); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        c = 0;
        do step(c); while (done !== 1'b1);
        q = rdata;
    endtask : acc
    task automatic len(input int p);
        chk("cycles", 1, 32'(c >= DIV * p - 2 && c <= DIV * p + 4));
    endtask : len
    function automatic logic [31:0] cfg(input int ab, win, cd, d, e, f, rdy, as, pol);
        return 32'((ab << EBC_F_AB) | (win << EBC_F_WIN) | (cd << EBC_F_C) | (d << EBC_F_D) | (e << EBC_F_E)
            | (f << EBC_F_F) | (rdy << EBC_F_RDYEN) | (as << EBC_F_ASYNC) | (pol << EBC_F_POL));
    endfunction : cfg
    // Tests run back to back from reset release.
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(EBC_CTRL_OFS, 32'(EBC_CTRL_RST), EBC_RESP_OKAY);
        axi_rd(EBC_STATUS_OFS, 32'(EBC_IDLE), EBC_RESP_OKAY);
        for (int i = 0; i < EBC_REGIONS; i++) axi_rd(EBC_TIMING_OFS + 8'(4 * i), 32'(EBC_TIMING_RST), EBC_RESP_OKAY);
        axi_rd(8'h40, 32'h0, EBC_RESP_SLVERR);
        axi_wr(8'h40, 32'h1, EBC_RESP_SLVERR);
        axi_wr(EBC_CTRL_OFS, 32'h1, EBC_RESP_OKAY);
        $display("test registers done");
        acc(1'b0, 2'h0, 24'h2, 16'h0);
        chk("read", 16'h2345, q);
        len(34);
        axi_wr(EBC_TIMING_OFS + 8'h4, cfg(0, 0, 0, 0, 0, 0, 0, 0, 0), EBC_RESP_OKAY);
        acc(1'b1, 2'h1, 24'h1, 16'hA5C3);
        len(2);
        axi_wr(EBC_TIMING_OFS + 8'h8, cfg(1, 3, 3, 1, 3, 3, 0, 0, 0), EBC_RESP_OKAY);
        acc(1'b1, 2'h2, 24'h3, 16'h5A3C);
        len(16);
        acc(1'b0, 2'h0, 24'h1, 16'h0);
        chk("read", 16'hA5C3, q);
        acc(1'b0, 2'h0, 24'h3, 16'h0);
        chk("read", 16'h5A3C, q);
        $display("test phases done");
        for (int p = 0; p < 2; p++)
            for (int a = 0; a < 2; a++)
                for (int w = 0; w < 2; w++)
                begin
                    rdy_pol <= p[0];
                    rdy_wait <= 3 * w;
                    axi_wr(EBC_TIMING_OFS + 8'hC, cfg(0, 0, 0, 0, 0, 0, 1, a, p), EBC_RESP_OKAY);
                    acc(1'b1, 2'h3, 24'h0, 16'h0F0F);
                    lat[p][a][w] = c;
                end
        for (int p = 0; p < 2; p++)
        begin
            chk("ready wait", 1, 32'(lat[p][0][1] > lat[p][0][0] + DIV));
            chk("async wait", 1, 32'(lat[p][1][0] >= lat[p][0][0] + DIV));
            chk("access first", 1, 32'(lat[p][0][0] >= 2 * DIV));
        end
        $display("test ready done");
        fork
            acc(1'b0, 2'h0, 24'h0, 16'h0);
            begin
                repeat (20) @(posedge aclk);
                hold_n <= 1'b0;
            end
        join
        chk("ack at done", 1, hold_acknowledge_n);
        chk("read", 16'h0F0F, q);
        n = 0;
        do step(n); while (hold_acknowledge_n !== 1'b0);
        fork
            acc(1'b0, 2'h0, 24'h1, 16'h0);
            begin
                repeat (3) @(posedge aclk);
                chk("bus request", 0, bus_request_out_n);
                chk("req_ready", 0, req_ready);
                chk("ctrl_oe_n", 1, ctrl_oe_n);
                chk("ale", 0, ext_addr_latch);
                hold_n <= 1'b1;
                n = 0;
                do step(n); while (hold_acknowledge_n !== 1'b1);
            end
        join
        chk("read", 16'hA5C3, q);
        $display("test hold done");
        test_done();
    end
endmodule : testbench
